// ---- verif/scd_mem_model.sv ----
// Read-only memory model holding the two compared strings
`timescale 1ns/1ps
`default_nettype none
module scd_mem_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // Read port from the unit, and the latency setting from the bench
  input  wire logic        mem_rd_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [3:0]  lat_i,
  output logic             mem_ack_o,
  output logic [15:0]      mem_rdata_o
);
  logic [15:0] mem [0:8191];
  logic [3:0]  wait_r;
  logic [15:0] last_r;
  assign mem_ack_o   = mem_rd_i && (wait_r >= lat_i);
  // Idle bus shows inverted data so stale values never look valid
  assign mem_rdata_o = mem_ack_o ? mem[mem_addr_i[12:0]] : ~last_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_r <= 4'h0;
      last_r <= 16'h0000;
    end else if (mem_ack_o) begin
      wait_r <= 4'h0;
      last_r <= mem_rdata_o;
    end else if (mem_rd_i) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // scd_mem_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the string compare-decrement unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, perr;
  logic        mem_rd, mem_byte, mem_ack, irq, irq_ack, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, mem_addr;
  logic [15:0] mem_rdata;
  logic [3:0]  lat;
  int          miscompares, checks;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] FLG = 32'h0000_000E;
  scd_unit i_scd_unit (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_rd_o(mem_rd),
    .mem_addr_o(mem_addr), .mem_byte_o(mem_byte), .mem_ack_i(mem_ack),
    .mem_rdata_i(mem_rdata), .irq_i(irq), .irq_ack_o(irq_ack), .busy_o(busy));
  scd_mem_model i_mem (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .mem_rd_i(mem_rd),
    .mem_addr_i(mem_addr), .lat_i(lat), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] want);
    apb(1'b0, a, 32'h0000_0000);
    check(q & m, want);
  endtask
  task automatic idle;
    int n;
    n = 0;
    repeat (2) @(negedge clock_i);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 3000) miscompares++;
  endtask
  function automatic logic [15:0] op0(input logic w, input logic [3:0] sub);
    return {scd_pkg::OP_PREFIX, w, 4'h2, sub};
  endfunction
  function automatic logic [15:0] op1(input logic [3:0] sel);
    return {scd_pkg::W1_TOP, 4'h4, 4'h3, sel};
  endfunction
  task automatic load(input logic [15:0] i0, input logic [15:0] i1, input logic [31:0] s,
                      input logic [31:0] d, input logic [15:0] c, input logic seg);
    wr(scd_pkg::OFS_INSTR0, {16'h0000, i0});
    wr(scd_pkg::OFS_INSTR1, {16'h0000, i1});
    wr(scd_pkg::OFS_SRC, s);
    wr(scd_pkg::OFS_DST, d);
    wr(scd_pkg::OFS_CNT, {16'h0000, c});
    wr(scd_pkg::OFS_CTRL, {30'h0, seg, 1'b1});
  endtask
  function automatic logic cond_exp(input logic [3:0] sel, input logic [15:0] d,
                                    input logic [15:0] s);
    logic [15:0] r;
    logic        c, z, n, v, lt, base;
    r = d - s;
    c = d < s;
    z = r == 16'h0000;
    n = r[15];
    v = (d[15] != s[15]) && (r[15] != d[15]);
    lt = n ^ v;
    case (sel[2:0])
      3'h0: base = 1'b0;
      3'h1: base = lt;
      3'h2: base = z | lt;
      3'h3: base = c | z;
      3'h4: base = v;
      3'h5: base = n;
      3'h6: base = z;
      default: base = c;
    endcase
    // Upper half of the selector codes is the negation of the lower half
    return base ^ sel[3];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_single;
    i_mem.mem[13'h0000] = 16'h00FF;
    load(op0(1'b0, scd_pkg::SUB_SINGLE), op1(scd_pkg::COND_UGE), 32'h3000, 32'h2000, 16'h1, 1'b0);
    @(negedge clock_i);
    check({31'h0, mem_byte}, 32'h1);
    idle();
    rd_chk(scd_pkg::OFS_CYC, ALL, scd_pkg::SINGLE_CYCLES);
    rd_chk(scd_pkg::OFS_STAT, FLG, 32'h0000_000A);
    rd_chk(scd_pkg::OFS_SRC, ALL, 32'h0000_2FFF);
    rd_chk(scd_pkg::OFS_DST, ALL, 32'h0000_1FFF);
    rd_chk(scd_pkg::OFS_CNT, ALL, 32'h0000_0000);
    check({16'h0000, i_mem.mem[13'h0000]}, 32'h0000_00FF);
  endtask
  task automatic t_cc_all;
    i_mem.mem[13'h0400] = 16'h8000;
    i_mem.mem[13'h0500] = 16'h0001;
    for (int k = 0; k < 16; k++) begin
      load(op0(1'b1, scd_pkg::SUB_SINGLE), op1(k[3:0]), 32'h0500, 32'h0400, 16'h5, 1'b0);
      idle();
      rd_chk(scd_pkg::OFS_STAT, 32'h2,
             {30'h0, cond_exp(k[3:0], 16'h8000, 16'h0001), 1'b0});
    end
  endtask
  task automatic t_word_rep;
    for (int k = 0; k < 4; k++) begin
      i_mem.mem[13'h1000 + 2 * k] = 16'h0002 * k[15:0];
      i_mem.mem[13'h0000 + 2 * k] = (k == 1 || k == 2) ? 16'h0001 : 16'h0000;
    end
    lat <= 4'h2;
    load(op0(1'b1, scd_pkg::SUB_REPEAT), op1(scd_pkg::COND_EQ), 32'h2006, 32'h1006, 16'h4, 1'b0);
    idle();
    lat <= 4'h0;
    rd_chk(scd_pkg::OFS_STAT, FLG, 32'h0000_000A);
    rd_chk(scd_pkg::OFS_SRC, ALL, 32'h0000_1FFE);
    rd_chk(scd_pkg::OFS_DST, ALL, 32'h0000_0FFE);
  endtask
  task automatic t_byte_rep;
    for (int k = 0; k < 3; k++) begin
      i_mem.mem[13'h0100 + k] = 16'h0001;
      i_mem.mem[13'h0200 + k] = 16'h0005;
    end
    load(op0(1'b0, scd_pkg::SUB_REPEAT), op1(scd_pkg::COND_EQ), 32'h0202, 32'h0102, 16'h3, 1'b0);
    idle();
    rd_chk(scd_pkg::OFS_STAT, FLG, 32'h0000_000C);
    rd_chk(scd_pkg::OFS_DST, ALL, 32'h0000_00FF);
    load(op0(1'b0, scd_pkg::SUB_REPEAT), op1(scd_pkg::COND_ULT), 32'h0202, 32'h0102, 16'h0, 1'b0);
    idle();
    rd_chk(scd_pkg::OFS_STAT, FLG, 32'h0000_0006);
    rd_chk(scd_pkg::OFS_CNT, ALL, 32'h0000_FFFF);
    rd_chk(scd_pkg::OFS_SRC, ALL, 32'h0000_0201);
  endtask
  task automatic t_seg;
    load(op0(1'b1, scd_pkg::SUB_SINGLE), op1(scd_pkg::COND_T), 32'h0005_0100,
         32'h0007_0200, 16'h2, 1'b1);
    @(negedge clock_i);
    check(mem_addr, 32'h0005_0100);
    check({31'h0, mem_byte}, 32'h0);
    idle();
    rd_chk(scd_pkg::OFS_SRC, ALL, 32'h0005_00FE);
    rd_chk(scd_pkg::OFS_DST, ALL, 32'h0007_01FE);
    rd_chk(scd_pkg::OFS_STAT, 32'h8, 32'h0);
  endtask
  task automatic t_irq;
    int n;
    n = 0;
    wr(scd_pkg::OFS_PC, 32'h0000_0456);
    load(op0(1'b1, scd_pkg::SUB_REPEAT), op1(scd_pkg::COND_F), 32'h0400, 32'h0300, 16'h6, 1'b0);
    irq <= 1'b1;
    do begin
      @(negedge clock_i);
      n++;
    end while (irq_ack !== 1'b1 && n < 300);
    check({31'h0, irq_ack}, 32'h1);
    check({31'h0, busy}, 32'h0);
    @(posedge clock_i);
    irq <= 1'b0;
    @(negedge clock_i);
    check({31'h0, irq_ack}, 32'h0);
    rd_chk(scd_pkg::OFS_SPC, ALL, 32'h0000_0456);
    rd_chk(scd_pkg::OFS_STAT, 32'h48, 32'h40);
    wr(scd_pkg::OFS_CTRL, 32'h1);
    idle();
    rd_chk(scd_pkg::OFS_CNT, ALL, 32'h0);
    rd_chk(scd_pkg::OFS_DST, ALL, 32'h0000_02F4);
  endtask
  task automatic t_illegal;
    load(op0(1'b1, scd_pkg::SUB_SINGLE) & 16'hFF0F, op1(scd_pkg::COND_T), 32'h10, 32'h20,
         16'h1, 1'b0);
    idle();
    rd_chk(scd_pkg::OFS_STAT, 32'h21, 32'h20);
    rd_chk(12'h0FC, ALL, 32'h0);
    check({31'h0, perr}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #(scd_pkg::CLK_PERIOD_NS / 2) clock_i = ~clock_i;
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    miscompares++;
    stop_test();
  end
  initial begin
    {sys_rst_i, psel, penable, pwrite, irq} = 5'h10;
    {paddr, pwdata, lat} = 48'h0;
    for (int i = 0; i < 8192; i++) i_mem.mem[i] = 16'h0000;
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_single();
    t_cc_all();
    t_word_rep();
    t_byte_rep();
    t_seg();
    t_irq();
    t_illegal();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire

// ---- verilog/scd_cond_eval.sv ----
// Subtract-compare of two string elements and condition selector evaluation
`timescale 1ns/1ps
`default_nettype none
module scd_cond_eval (
  // Operands
  input  wire logic [15:0] dst_i,
  input  wire logic [15:0] src_i,
  input  wire logic        word_i,
  input  wire logic [3:0]  sel_i,
  // Results
  output logic             match_o,
  output logic             borrow_o,
  output logic             sign_o
);
  logic [16:0] diff_w;
  logic [8:0]  diff_b;
  logic        zero;
  logic        ovf;
  logic        dst_neg;
  logic        src_neg;

  assign diff_w   = {1'b0, dst_i} - {1'b0, src_i};
  assign diff_b   = {1'b0, dst_i[7:0]} - {1'b0, src_i[7:0]};
  assign borrow_o = word_i ? diff_w[16] : diff_b[8];
  assign sign_o   = word_i ? diff_w[15] : diff_b[7];
  assign zero     = word_i ? (diff_w[15:0] == 16'h0000) : (diff_b[7:0] == 8'h00);
  assign dst_neg  = word_i ? dst_i[15] : dst_i[7];
  assign src_neg  = word_i ? src_i[15] : src_i[7];
  assign ovf      = (dst_neg != src_neg) && (sign_o != dst_neg);

  always_comb begin
    unique case (sel_i)
      scd_pkg::COND_F:   match_o = 1'b0;
      scd_pkg::COND_LT:  match_o = sign_o ^ ovf;
      scd_pkg::COND_LE:  match_o = zero | (sign_o ^ ovf);
      scd_pkg::COND_ULE: match_o = borrow_o | zero;
      scd_pkg::COND_OV:  match_o = ovf;
      scd_pkg::COND_MI:  match_o = sign_o;
      scd_pkg::COND_EQ:  match_o = zero;
      scd_pkg::COND_ULT: match_o = borrow_o;
      scd_pkg::COND_T:   match_o = 1'b1;
      scd_pkg::COND_GE:  match_o = ~(sign_o ^ ovf);
      scd_pkg::COND_GT:  match_o = ~(zero | (sign_o ^ ovf));
      scd_pkg::COND_UGT: match_o = ~(borrow_o | zero);
      scd_pkg::COND_NOV: match_o = ~ovf;
      scd_pkg::COND_PL:  match_o = ~sign_o;
      scd_pkg::COND_NE:  match_o = ~zero;
      scd_pkg::COND_UGE: match_o = ~borrow_o;
    endcase
  end
endmodule // scd_cond_eval
`default_nettype wire

// ---- verilog/scd_pkg.sv ----
// Constants, register map and field layout of the string compare-decrement unit
`default_nettype none
package scd_pkg;
  // APB byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_INSTR0 = 12'h004;
  localparam logic [11:0] OFS_INSTR1 = 12'h008;
  localparam logic [11:0] OFS_SRC    = 12'h00C;
  localparam logic [11:0] OFS_DST    = 12'h010;
  localparam logic [11:0] OFS_CNT    = 12'h014;
  localparam logic [11:0] OFS_STAT   = 12'h018;
  localparam logic [11:0] OFS_PC     = 12'h01C;
  localparam logic [11:0] OFS_SPC    = 12'h020;
  localparam logic [11:0] OFS_CYC    = 12'h024;
  // Control bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SEG_BIT   = 1;
  // Status bits
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_MATCH_BIT = 1;
  localparam int STAT_BORR_BIT  = 2;
  localparam int STAT_EXH_BIT   = 3;
  localparam int STAT_SIGN_BIT  = 4;
  localparam int STAT_ILL_BIT   = 5;
  localparam int STAT_INTR_BIT  = 6;
  // Instruction encoding
  localparam logic [6:0] OP_PREFIX  = 7'h5D;
  localparam logic [3:0] SUB_SINGLE = 4'hA;
  localparam logic [3:0] SUB_REPEAT = 4'hE;
  localparam logic [3:0] W1_TOP     = 4'h0;
  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] RST_HALF  = 16'h0000;
  // Timing
  localparam int          CLK_PERIOD_NS    = 100;
  localparam logic [31:0] SINGLE_CYCLES    = 32'h0000_0019;
  localparam logic [2:0]  INT_EXTRA_CYCLES = 3'h7;
  // Condition selector codes
  localparam logic [3:0] COND_F   = 4'h0;
  localparam logic [3:0] COND_LT  = 4'h1;
  localparam logic [3:0] COND_LE  = 4'h2;
  localparam logic [3:0] COND_ULE = 4'h3;
  localparam logic [3:0] COND_OV  = 4'h4;
  localparam logic [3:0] COND_MI  = 4'h5;
  localparam logic [3:0] COND_EQ  = 4'h6;
  localparam logic [3:0] COND_ULT = 4'h7;
  localparam logic [3:0] COND_T   = 4'h8;
  localparam logic [3:0] COND_GE  = 4'h9;
  localparam logic [3:0] COND_GT  = 4'hA;
  localparam logic [3:0] COND_UGT = 4'hB;
  localparam logic [3:0] COND_NOV = 4'hC;
  localparam logic [3:0] COND_PL  = 4'hD;
  localparam logic [3:0] COND_NE  = 4'hE;
  localparam logic [3:0] COND_UGE = 4'hF;
endpackage
`default_nettype wire

// ---- verilog/scd_unit.sv ----
// String compare-decrement execution unit with APB register access
`timescale 1ns/1ps
`default_nettype none
module scd_unit (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Memory read port
  output logic             mem_rd_o,
  output logic [31:0]      mem_addr_o,
  output logic             mem_byte_o,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i,
  // Interrupt handshake and status
  input  wire logic        irq_i,
  output logic             irq_ack_o,
  output logic             busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_SRC, ST_RD_DST, ST_UPDATE, ST_PAD, ST_INTR
  } scd_state_type;

  // pointer step by element size, offset part only
  function automatic logic [31:0] ptr_step(input logic [31:0] ptr, input logic word);
    logic [15:0] ofs;
    ofs = ptr[15:0] - (word ? 16'h0002 : 16'h0001);
    return {ptr[31:16], ofs};
  endfunction

  // unsegmented pointers use the low word only
  function automatic logic [31:0] ptr_addr(input logic [31:0] ptr, input logic seg);
    return seg ? ptr : {16'h0000, ptr[15:0]};
  endfunction

  scd_state_type state_r;
  scd_state_type state_nxt;
  logic [31:0] instr0_r;
  logic [31:0] instr1_r;
  logic [31:0] src_ptr_r;
  logic [31:0] dst_ptr_r;
  logic [15:0] cnt_r;
  logic [31:0] pc_r;
  logic [31:0] saved_pc_r;
  logic [31:0] cyc_r;
  logic [31:0] prdata_r;
  logic [15:0] src_data_r;
  logic [15:0] dst_data_r;
  logic [2:0]  int_cnt_r;
  logic        seg_r;
  logic        match_r;
  logic        borrow_r;
  logic        exh_r;
  logic        sign_r;
  logic        ill_r;
  logic        intr_r;
  logic        irq_meta_r;
  logic        irq_sync_r;
  logic        irq_ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire         setup_ph  = psel_i & ~penable_i;
  wire         access_ph = psel_i & penable_i;
  wire         hit_ctrl  = paddr_i == scd_pkg::OFS_CTRL;
  wire         hit_i0    = paddr_i == scd_pkg::OFS_INSTR0;
  wire         hit_i1    = paddr_i == scd_pkg::OFS_INSTR1;
  wire         hit_src   = paddr_i == scd_pkg::OFS_SRC;
  wire         hit_dst   = paddr_i == scd_pkg::OFS_DST;
  wire         hit_cnt   = paddr_i == scd_pkg::OFS_CNT;
  wire         hit_stat  = paddr_i == scd_pkg::OFS_STAT;
  wire         hit_pc    = paddr_i == scd_pkg::OFS_PC;
  wire         hit_spc   = paddr_i == scd_pkg::OFS_SPC;
  wire         hit_cyc   = paddr_i == scd_pkg::OFS_CYC;
  wire         mapped    = hit_ctrl | hit_i0 | hit_i1 | hit_src | hit_dst | hit_cnt
                         | hit_stat | hit_pc | hit_spc | hit_cyc;
  wire         wr_en     = access_ph & pwrite_i & mapped;
  wire         idle      = state_r == ST_IDLE;
  // Operand writes during execution would tear the running string walk
  wire         wr_idle   = wr_en & idle;
  wire [31:0]  stat_word = {25'h0, intr_r, ill_r, sign_r, exh_r, borrow_r, match_r,
                            ~idle};
  wire [31:0]  rd_mux    = hit_ctrl ? {30'h0, seg_r, 1'b0} :
                           hit_i0   ? instr0_r :
                           hit_i1   ? instr1_r :
                           hit_src  ? src_ptr_r :
                           hit_dst  ? dst_ptr_r :
                           hit_cnt  ? {16'h0000, cnt_r} :
                           hit_stat ? stat_word :
                           hit_pc   ? pc_r :
                           hit_spc  ? saved_pc_r :
                           hit_cyc  ? cyc_r : 32'h0000_0000;

  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph & ~mapped;
  assign prdata_o  = prdata_r;

  // Read data sampled in setup so the access phase sees a flop
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_r <= scd_pkg::RST_WORD;
    end else if (setup_ph & ~pwrite_i) begin
      prdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  // two-word opcode check
  wire         op_ok   = instr0_r[15:9] == scd_pkg::OP_PREFIX && instr0_r[7:4] != 4'h0
                       && instr1_r[15:12] == scd_pkg::W1_TOP && instr1_r[7:4] != 4'h0
                       && (instr0_r[3:0] == scd_pkg::SUB_SINGLE
                           || instr0_r[3:0] == scd_pkg::SUB_REPEAT);
  wire         is_word = instr0_r[8];
  wire         is_rep  = instr0_r[3:0] == scd_pkg::SUB_REPEAT;
  wire [3:0]   cond_sel  = instr1_r[3:0];
  wire         start_wr  = wr_idle & hit_ctrl & pwdata_i[scd_pkg::CTRL_START_BIT];
  wire         start_ok  = start_wr & op_ok;
  // zero counter wraps to 16'hFFFF, giving 65536 passes
  wire [15:0]  cnt_dec = cnt_r - 16'h0001;
  wire         cnt_zero = cnt_dec == 16'h0000;
  wire         cmp_match;
  wire         cmp_borrow;
  wire         cmp_sign;
  wire         int_done = int_cnt_r == scd_pkg::INT_EXTRA_CYCLES - 3'h1;

  scd_cond_eval u_cond (
    .dst_i    (dst_data_r),
    .src_i    (src_data_r),
    .word_i   (is_word),
    .sel_i    (cond_sel),
    .match_o  (cmp_match),
    .borrow_o (cmp_borrow),
    .sign_o   (cmp_sign)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:   state_nxt = start_ok ? ST_RD_SRC : ST_IDLE;
      ST_RD_SRC: state_nxt = mem_ack_i ? ST_RD_DST : ST_RD_SRC;
      ST_RD_DST: state_nxt = mem_ack_i ? ST_UPDATE : ST_RD_DST;
      ST_UPDATE: begin
        if (!is_rep) begin
          state_nxt = ST_PAD;
        end else if (cmp_match || cnt_zero) begin
          state_nxt = ST_IDLE;
        end else if (irq_sync_r) begin
          state_nxt = ST_INTR;
        end else begin
          state_nxt = ST_RD_SRC;
        end
      end
      // single step holds for the full cycle count
      ST_PAD:    state_nxt = (cyc_r >= scd_pkg::SINGLE_CYCLES - 32'h0000_0001) ? ST_IDLE : ST_PAD;
      ST_INTR:   state_nxt = int_done ? ST_IDLE : ST_INTR;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign mem_rd_o   = (state_r == ST_RD_SRC) || (state_r == ST_RD_DST);
  assign mem_addr_o = (state_r == ST_RD_DST) ? ptr_addr(dst_ptr_r, seg_r)
                                             : ptr_addr(src_ptr_r, seg_r);
  assign mem_byte_o = ~is_word;
  assign busy_o     = ~idle;
  assign irq_ack_o  = irq_ack_r;

  // Interrupt pin synchroniser
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
    end else begin
      irq_meta_r <= irq_i;
      irq_sync_r <= irq_meta_r;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_data_r <= scd_pkg::RST_HALF;
      dst_data_r <= scd_pkg::RST_HALF;
      int_cnt_r  <= 3'h0;
      irq_ack_r  <= 1'b0;
      cyc_r      <= scd_pkg::RST_WORD;
    end else begin
      if (state_r == ST_RD_SRC && mem_ack_i) begin
        src_data_r <= is_word ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
      end
      if (state_r == ST_RD_DST && mem_ack_i) begin
        dst_data_r <= is_word ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
      end
      int_cnt_r <= (state_r == ST_INTR) ? int_cnt_r + 3'h1 : 3'h0;
      irq_ack_r <= (state_r == ST_INTR) && int_done;
      cyc_r     <= start_ok ? scd_pkg::RST_WORD : (idle ? cyc_r : cyc_r + 32'h0000_0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural registers
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      instr0_r   <= scd_pkg::RST_WORD;
      instr1_r   <= scd_pkg::RST_WORD;
      pc_r       <= scd_pkg::RST_WORD;
      saved_pc_r <= scd_pkg::RST_WORD;
      seg_r      <= 1'b0;
    end else begin
      if (wr_idle & hit_i0) instr0_r <= {16'h0000, pwdata_i[15:0]};
      if (wr_idle & hit_i1) instr1_r <= {16'h0000, pwdata_i[15:0]};
      if (wr_idle & hit_pc) pc_r <= pwdata_i;
      if (wr_idle & hit_ctrl) seg_r <= pwdata_i[scd_pkg::CTRL_SEG_BIT];
      if (state_r == ST_INTR && int_done) saved_pc_r <= pc_r;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_ptr_r <= scd_pkg::RST_WORD;
      dst_ptr_r <= scd_pkg::RST_WORD;
      cnt_r     <= scd_pkg::RST_HALF;
    end else if (state_r == ST_UPDATE) begin
      src_ptr_r <= ptr_step(src_ptr_r, is_word);
      dst_ptr_r <= ptr_step(dst_ptr_r, is_word);
      cnt_r     <= cnt_dec;
    end else begin
      if (wr_idle & hit_src) src_ptr_r <= pwdata_i;
      if (wr_idle & hit_dst) dst_ptr_r <= pwdata_i;
      if (wr_idle & hit_cnt) cnt_r <= pwdata_i[15:0];
    end
  end

  // Sticky error flags: write one to clear, a new event wins
  wire ill_clr  = wr_en & hit_stat & pwdata_i[scd_pkg::STAT_ILL_BIT];
  wire intr_clr = wr_en & hit_stat & pwdata_i[scd_pkg::STAT_INTR_BIT];

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      match_r  <= 1'b0;
      borrow_r <= 1'b0;
      exh_r    <= 1'b0;
      sign_r   <= 1'b0;
      ill_r    <= 1'b0;
      intr_r   <= 1'b0;
    end else begin
      // flags follow the last compare performed
      if (state_r == ST_UPDATE) begin
        match_r  <= cmp_match;
        borrow_r <= cmp_borrow;
        sign_r   <= cmp_sign;
        exh_r    <= cnt_zero;
      end
      ill_r  <= (start_wr & ~op_ok) | (ill_r & ~ill_clr);
      intr_r <= ((state_r == ST_INTR) & int_done) | (intr_r & ~intr_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_decode_start: assert property (start_wr |=> (state_r == ST_RD_SRC) == $past(op_ok))
    else $error("start did not follow decode result");
  a_single_len: assert property (state_r == ST_PAD && state_nxt == ST_IDLE |->
      cyc_r >= scd_pkg::SINGLE_CYCLES - 32'h0000_0001)
    else $error("single step ended before 25 cycles");
  a_match_flag: assert property (state_r == ST_UPDATE |=> match_r == $past(cmp_match))
    else $error("match flag not taken from compare");
  a_borrow_flag: assert property (state_r == ST_UPDATE |=>
      borrow_r == $past(dst_data_r < src_data_r))
    else $error("borrow flag wrong");
  a_ptr_step: assert property (state_r == ST_UPDATE |=>
      src_ptr_r[15:0] == $past(src_ptr_r[15:0]) - ($past(is_word) ? 16'h0002 : 16'h0001)
      && dst_ptr_r[15:0] == $past(dst_ptr_r[15:0]) - ($past(is_word) ? 16'h0002 : 16'h0001))
    else $error("pointer step wrong");
  a_cnt_dec: assert property (state_r == ST_UPDATE |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("counter not decremented");
  a_exh_flag: assert property (state_r == ST_UPDATE |=> exh_r == (cnt_r == 16'h0000))
    else $error("exhausted flag disagrees with counter");
  a_repeat_loop: assert property (
      state_r == ST_UPDATE && is_rep && !cmp_match && !cnt_zero && !irq_sync_r
      |=> state_r == ST_RD_SRC)
    else $error("repeat did not loop");
  a_repeat_stop: assert property (
      state_r == ST_UPDATE && is_rep && (cmp_match || cnt_zero)
      |=> state_r == ST_IDLE)
    else $error("repeat did not stop");
  a_intr_len: assert property ($rose(state_r == ST_INTR) |-> (state_r == ST_INTR) [*7]
      ##1 (state_r == ST_IDLE && irq_ack_o && saved_pc_r == pc_r))
    else $error("interrupt exit timing or saved pc wrong");

  c_single: cover property (state_r == ST_PAD ##1 state_r == ST_IDLE);
  c_rep_match: cover property (state_r == ST_UPDATE && is_rep && cmp_match);
  c_rep_exh: cover property (state_r == ST_UPDATE && is_rep && cnt_zero && !cmp_match);
  c_intr: cover property (irq_ack_o);
endmodule // scd_unit
`default_nettype wire
